// ===== hdl/pfb_flag_bank.sv
// second peripheral interrupt flag bank with enables, group gating and irq output
// assumes event pulses and timer1 count come from logic on clk, bus master on clk
// registers: flag bank, two enables, control, compare value and capture value
// every access costs one wait state; the irq pin lags its cause by one clock
// flags follow read/write semantics: software writes 0 to clear, an event beats it
`timescale 1ns/1ps

// Notes on behaviour
// - In capture mode a timer1 capture sets the unit 2 flag at bit 0, which stays until software writes 0.
// - In compare mode a timer1 match with the compare value sets the unit 2 flag, held until cleared.
// - Every peripheral source has its own enable bit, held in two enable registers.
// - With priority levels off, no peripheral request reaches the cpu unless the group enable is set.
// - Flags set on their events regardless of their enables and of the global enable.
// - An enable at 1 lets its flag request an interrupt, at 0 it masks it and leaves the flag alone.
// - The global enable in bit 7 of the control register gates every interrupt request.
module pfb_flag_bank (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic [7:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire pfb_pkg::pfb_events_t        periphEvents,
    input  wire logic [pfb_pkg::PFB_TMR_W-1:0] timer1Count,
    input  wire logic [7:0]                  flagReg1,
    output logic      [7:0]                  peripheral_flag_reg2,
    output logic                             cpuIrq
);
    import pfb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0]           flags;
        logic [7:0]           enable1;
        logic [7:0]           enable2;
        logic [7:0]           control;
        logic [PFB_TMR_W-1:0] compareVal;
        logic [PFB_TMR_W-1:0] captureVal;
        logic                 matchPrev;
        logic                 waitReq;
        logic [31:0]          readData;
        logic                 irq;
    } pfb_state_t;

    pfb_state_t st;
    pfb_state_t next_st;

    // bus decode
    logic                 busReq;
    logic                 busAccept;
    logic                 lane0;
    logic [31:0]          readWord;
    logic [7:0]           readMux;

    // register write strobes
    logic                 wrFlag;
    logic                 wrEnable1;
    logic                 wrEnable2;
    logic                 wrControl;
    logic                 wrCompare;
    logic [PFB_TMR_W-1:0] cmpNext;

    // event and interrupt terms
    pfb_mode_t            ccpMode;
    logic                 matchNow;
    logic                 captureHit;
    logic                 compareHit;
    logic [7:0]           eventVec;
    logic [7:0]           flagNext;
    logic [7:0]           pendingVec;
    logic [7:0]           pendingReg1;
    logic                 periphPending;
    logic                 groupOpen;
    logic                 irqNext;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, accept on the edge waitrequest is low
    always_comb begin
        busReq    = avs_read || avs_write;
        busAccept = busReq && !st.waitReq;  // edge where master sees waitrequest low
        lane0     = avs_byteenable[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // unit 2 mode and its two event sources
    always_comb begin
        ccpMode    = pfb_mode_t'(st.control[PFB_BIT_MODE_HI:PFB_BIT_MODE_LO]);
        matchNow   = (timer1Count == st.compareVal);
        captureHit = (ccpMode == PFB_MODE_CAPTURE) && periphEvents.ccpCapture;
        compareHit = (ccpMode == PFB_MODE_COMPARE) && matchNow && !st.matchPrev;
    end

    ////////////////////////////////////////////////////////////////////////////
    // event pulses placed at their flag positions
    always_comb begin
        eventVec = 8'h00;
        eventVec[PFB_BIT_OSC_FAIL] = periphEvents.oscFail;
        eventVec[PFB_BIT_CMP_CHG]  = periphEvents.cmpChange;
        eventVec[PFB_BIT_BUS_COLL] = periphEvents.busCollision;
        eventVec[PFB_BIT_VOLT_DET] = periphEvents.voltDetect;
        eventVec[PFB_BIT_TMR3_OVF] = periphEvents.tmr3Overflow;
        case (ccpMode)
            PFB_MODE_CAPTURE: begin
                eventVec[PFB_BIT_CAPCOMP2] = captureHit;
            end
            PFB_MODE_COMPARE: begin
                eventVec[PFB_BIT_CAPCOMP2] = compareHit;
            end
            default: begin
                eventVec[PFB_BIT_CAPCOMP2] = 1'b0;  // off and pwm leave the flag unused
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // 8-bit register readback
    always_comb begin
        case (avs_address)
            PFB_OFS_FLAG2: begin
                readMux = st.flags & PFB_FLAG_MASK;
            end
            PFB_OFS_ENABLE1: begin
                readMux = st.enable1;
            end
            PFB_OFS_ENABLE2: begin
                readMux = st.enable2;
            end
            PFB_OFS_CONTROL: begin
                readMux = st.control & PFB_CTRL_MASK;
            end
            default: begin
                readMux = 8'h00;    // unmapped offsets read as zero
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // full read word, timer registers zero-extended
    always_comb begin
        case (avs_address)
            PFB_OFS_COMPARE: begin
                readWord = 32'(st.compareVal);
            end
            PFB_OFS_CAPTURE: begin
                readWord = 32'(st.captureVal);
            end
            default: begin
                readWord = 32'(readMux);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // write strobes: one per writable register, only at the accepting edge
    // lane 0 carries every 8-bit register; compare lanes are picked per byte
    always_comb begin
        wrFlag    = 1'b0;
        wrEnable1 = 1'b0;
        wrEnable2 = 1'b0;
        wrControl = 1'b0;
        wrCompare = 1'b0;
        if (busAccept && avs_write) begin
            case (avs_address)
                PFB_OFS_FLAG2: begin
                    wrFlag = lane0;
                end
                PFB_OFS_ENABLE1: begin
                    wrEnable1 = lane0;
                end
                PFB_OFS_ENABLE2: begin
                    wrEnable2 = lane0;
                end
                PFB_OFS_CONTROL: begin
                    wrControl = lane0;
                end
                PFB_OFS_COMPARE: begin
                    wrCompare = 1'b1;
                end
                default: begin
                    wrFlag = 1'b0;       // capture and unmapped offsets ignore writes
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare value, one byte per lane so a half write keeps the other byte
    for (genvar ln = 0; ln < PFB_TMR_W / 8; ln++) begin : g_cmp_lane
        logic laneOn;
        assign laneOn             = wrCompare && avs_byteenable[ln];
        assign cmpNext[ln*8 +: 8] = laneOn ? avs_writedata[ln*8 +: 8]
                                           : st.compareVal[ln*8 +: 8];
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-flag next value: an event sets, a write loads, reserved bits stay 0
    // the event term is or-ed with the write value so it beats a clear in the same cycle
    for (genvar i = 0; i < $bits(flagNext); i++) begin : g_flag
        logic implemented;
        logic setByEvent;
        logic loadBySw;
        logic requesting;
        assign implemented   = PFB_FLAG_MASK[i];
        assign setByEvent    = eventVec[i];
        assign loadBySw      = wrFlag ? avs_writedata[i] : st.flags[i];
        assign requesting    = st.flags[i] && st.enable2[i];
        assign flagNext[i]   = implemented && (setByEvent || loadBySw);
        assign pendingVec[i] = implemented && requesting;
    end

    ////////////////////////////////////////////////////////////////////////////
    // first flag register requests, each gated by its own enable bit
    for (genvar j = 0; j < $bits(flagReg1); j++) begin : g_reg1
        assign pendingReg1[j] = flagReg1[j] && st.enable1[j];
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt combination
    always_comb begin
        periphPending = |pendingVec | |pendingReg1;
        groupOpen     = st.control[PFB_BIT_PRIORITY_LEVELS_ENABLE] | st.control[PFB_BIT_PERIPHERAL_GROUP_ENABLE];
    end

    ////////////////////////////////////////////////////////////////////////////
    // irq request term, registered so the pin comes from a flip-flop
    always_comb begin
        irqNext = st.control[PFB_BIT_GIE] && groupOpen && periphPending;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        // everything holds unless a term below changes it
        next_st = st;

        // one wait state, then one acknowledge cycle
        next_st.waitReq = !(busReq && st.waitReq);
        if (busReq && st.waitReq && avs_read) begin
            next_st.readData = readWord;   // stands while waitrequest is low
        end else if (busAccept) begin
            next_st.readData = PFB_RDATA_NONE;
        end

        // register writes take effect at the accepting edge
        if (wrEnable1) begin
            next_st.enable1 = avs_writedata[7:0];
        end
        if (wrEnable2) begin
            next_st.enable2 = avs_writedata[7:0] & PFB_FLAG_MASK;
        end
        if (wrControl) begin
            next_st.control = avs_writedata[7:0] & PFB_CTRL_MASK;
        end
        next_st.compareVal = cmpNext;

        // events win over a software clear in the same cycle
        next_st.flags = flagNext;

        // capture latches the timer on the capture event
        if (captureHit) begin
            next_st.captureVal = timer1Count;
        end
        next_st.matchPrev = matchNow;

        // global enable gates everything, group enable gates peripherals while priority levels are off
        next_st.irq = irqNext;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // registers software sees
            st.flags      <= PFB_FLAG_RESET;
            st.enable1    <= PFB_EN_RESET;
            st.enable2    <= PFB_EN_RESET;
            st.control    <= PFB_EN_RESET;
            st.compareVal <= PFB_CMP_RESET;
            st.captureVal <= PFB_CMP_RESET;
            // bus and interrupt state
            st.matchPrev  <= 1'b0;
            st.waitReq    <= 1'b1;
            st.readData   <= PFB_RDATA_NONE;
            st.irq        <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flip-flops
    assign avs_readdata         = st.readData;
    assign avs_waitrequest      = st.waitReq;
    assign peripheral_flag_reg2 = st.flags;
    assign cpuIrq               = st.irq;

endmodule : pfb_flag_bank

// ===== inc/pfb_pkg.sv
// constants and carrier types of the second peripheral interrupt flag bank
// assumes a 32-bit avalon-mm slave port with byte addresses
package pfb_pkg;

    // register byte offsets
    localparam logic [7:0] PFB_OFS_FLAG2   = 8'h00;
    localparam logic [7:0] PFB_OFS_ENABLE1 = 8'h04;
    localparam logic [7:0] PFB_OFS_ENABLE2 = 8'h08;
    localparam logic [7:0] PFB_OFS_CONTROL = 8'h0C;
    localparam logic [7:0] PFB_OFS_COMPARE = 8'h10;
    localparam logic [7:0] PFB_OFS_CAPTURE = 8'h14;

    // flag register layout
    localparam int PFB_BIT_OSC_FAIL  = 7;
    localparam int PFB_BIT_CMP_CHG   = 6;
    localparam int PFB_BIT_BUS_COLL  = 3;
    localparam int PFB_BIT_VOLT_DET  = 2;
    localparam int PFB_BIT_TMR3_OVF  = 1;
    localparam int PFB_BIT_CAPCOMP2  = 0;
    localparam logic [7:0] PFB_FLAG_MASK  = 8'hCF;
    localparam logic [7:0] PFB_FLAG_RESET = 8'h00;
    localparam logic [7:0] PFB_EN_RESET   = 8'h00;

    // control register layout
    localparam int PFB_BIT_GIE      = 7;
    localparam int PFB_BIT_PERIPHERAL_GROUP_ENABLE     = 6;
    localparam int PFB_BIT_MODE_HI  = 2;
    localparam int PFB_BIT_MODE_LO  = 1;
    localparam int PFB_BIT_PRIORITY_LEVELS_ENABLE     = 0;
    localparam logic [7:0] PFB_CTRL_MASK = 8'hC7;

    // capture/compare unit 2 modes
    typedef enum logic [1:0] {
        PFB_MODE_OFF     = 2'h0,
        PFB_MODE_CAPTURE = 2'h1,
        PFB_MODE_COMPARE = 2'h2,
        PFB_MODE_PWM     = 2'h3
    } pfb_mode_t;

    localparam int          PFB_TMR_W      = 16;
    localparam logic [15:0] PFB_CMP_RESET  = 16'h0000;
    localparam logic [31:0] PFB_RDATA_NONE = 32'h0000_0000;

    // peripheral event pulses, one clock wide each
    typedef struct packed {
        logic oscFail;
        logic cmpChange;
        logic busCollision;
        logic voltDetect;
        logic tmr3Overflow;
        logic ccpCapture;
    } pfb_events_t;

endpackage : pfb_pkg

// ===== test/pfb_cpu_model.sv
// cpu interrupt entry model: counts taken interrupts
// assumes cpuIrq is a level on clk
`timescale 1ns/1ps
module pfb_cpu_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cpuIrq,
    output logic      [7:0] irqEntries
);
    logic irqLast;
    // one entry per rise of the request level
    always_ff @(posedge clk) begin
        irqLast    <= sys_rst ? 1'b0 : cpuIrq;
        irqEntries <= sys_rst ? 8'h00 : irqEntries + 8'(cpuIrq && !irqLast);
    end
endmodule : pfb_cpu_model

// ===== test/pfb_flag_bank_chk.sv
// port assertions of the flag bank
// assumes one clock, bound below
`timescale 1ns/1ps
module pfb_flag_bank_chk (
    input wire logic                          clk, sys_rst, avs_read, avs_write,
    input wire logic [7:0]                    avs_address,
    input wire logic [31:0]                   avs_writedata, avs_readdata,
    input wire logic [3:0]                    avs_byteenable,
    input wire logic                          avs_waitrequest, cpuIrq,
    input wire pfb_pkg::pfb_events_t          periphEvents,
    input wire logic [pfb_pkg::PFB_TMR_W-1:0] timer1Count,
    input wire logic [7:0]                    flagReg1, peripheral_flag_reg2
);
    import pfb_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] evBits;
    logic       wrDone;
    // event pulses placed at their flag positions
    assign evBits = {periphEvents[5:4], 2'h0, periphEvents[3:1], 1'h0};
    assign wrDone = avs_write && !avs_waitrequest;
    ////////////////////////////////////////////////////////////////////////////
    a_rsv_bits_zero: assert property (peripheral_flag_reg2[5:4] == 2'h0)
        else $error("reserved flags set");
    a_event_sets_flag: assert property (|evBits |=> &(peripheral_flag_reg2 | ~$past(evBits)))
        else $error("event lost");
    a_flag_sticky: assert property (|($past(peripheral_flag_reg2) & ~peripheral_flag_reg2)
        |-> $past(wrDone && avs_address == PFB_OFS_FLAG2))
        else $error("flag fell alone");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer");
    a_read_idle_zero: assert property (avs_waitrequest |-> avs_readdata == PFB_RDATA_NONE)
        else $error("readdata not zero");
    a_irq_needs_flag: assert property (cpuIrq |-> $past(|peripheral_flag_reg2 || |flagReg1))
        else $error("irq without flag");
    a_irq_drop_cause: assert property ($fell(cpuIrq) |-> $past(wrDone, 2) || $past(|flagReg1, 2))
        else $error("irq fell alone");
    cover property ($rose(cpuIrq));
    cover property (|evBits);
    cover property (avs_read && !avs_waitrequest);
endmodule : pfb_flag_bank_chk

bind pfb_flag_bank pfb_flag_bank_chk i_chk (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_address(avs_address), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_byteenable(avs_byteenable), .cpuIrq(cpuIrq),
    .avs_waitrequest(avs_waitrequest), .periphEvents(periphEvents), .timer1Count(timer1Count),
    .flagReg1(flagReg1), .peripheral_flag_reg2(peripheral_flag_reg2));

// ===== test/pfb_flag_bank_tb_top.sv
// register-level bench of the flag bank
// assumes pfb_pkg, model and checker compiled first
`timescale 1ns/1ps
module pfb_flag_bank_tb_top;
    import pfb_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        avs_waitrequest, cpuIrq;
    logic [7:0]  avs_address = 8'h00, flagReg1 = 8'h00, flag2, irqEntries;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [15:0] timer1Count = 16'h0000;
    pfb_events_t periphEvents = '0;
    int          miscompares = 0, checked = 0, cycles = 0;
    pfb_flag_bank i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .periphEvents(periphEvents), .timer1Count(timer1Count), .flagReg1(flagReg1),
        .peripheral_flag_reg2(flag2), .cpuIrq(cpuIrq));
    pfb_cpu_model i_cpu (.clk(clk), .sys_rst(sys_rst), .cpuIrq(cpuIrq), .irqEntries(irqEntries));
    always #5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic ev(input logic [5:0] e);
        periphEvents <= pfb_events_t'(e);
        @(posedge clk);
        periphEvents <= '0;
        @(posedge clk);
    endtask : ev
    task automatic irq(input logic e);
        repeat (2) @(negedge clk);
        chk("cpuIrq", cpuIrq, e);
        @(posedge clk);
    endtask : irq
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'h0);
        bus(0, 8'h20, 0); chk("unmapped", rd, 32'h0);
        ev(6'h3E); bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'hCE);
        chk("flagPort", flag2, 8'hCE);
        irq(0);
        $display("test reset and events done");
        bus(1, PFB_OFS_ENABLE2, 32'h02); bus(1, PFB_OFS_CONTROL, 32'h80); irq(0);
        bus(1, PFB_OFS_CONTROL, 32'hC0); irq(1);
        bus(1, PFB_OFS_CONTROL, 32'h40); irq(0);
        bus(1, PFB_OFS_CONTROL, 32'h81); irq(1);
        bus(1, PFB_OFS_FLAG2, 32'hFC); irq(0);
        bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'hCC);
        bus(1, PFB_OFS_ENABLE1, 32'h10); flagReg1 <= 8'h10; irq(1);
        flagReg1 <= 8'h00; irq(0);
        $display("test gating done");
        bus(1, PFB_OFS_CONTROL, 32'h02); timer1Count <= 16'h1234; ev(6'h01);
        bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'hCD);
        bus(0, PFB_OFS_CAPTURE, 0); chk("capture", rd, 32'h1234);
        bus(1, PFB_OFS_FLAG2, 0); bus(1, PFB_OFS_COMPARE, 32'hA5); bus(1, PFB_OFS_CONTROL, 32'h04);
        bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'h0);
        timer1Count <= 16'h00A5; repeat (3) @(posedge clk);
        bus(0, PFB_OFS_FLAG2, 0); chk("flag2", rd, 32'h01);
        chk("entries", irqEntries, 8'h03);
        $display("test capture compare done");
        finish_test();
    end
endmodule : pfb_flag_bank_tb_top
